// file: design/hccfg_pkg.sv
// Package of offsets, field positions, reset values and timing constants
package hccfg_pkg;

    // ************************************************************
    // Register offsets (byte addresses on the processor port)
    // ************************************************************
    localparam logic [15:0] HARDWARE_MODE_CONTROL_OFS = 16'h0300;
    localparam logic [15:0] IDENTIFICATION_OFS  = 16'h0304;
    localparam logic [15:0] SCRATCH_WORD_OFS    = 16'h0308;
    localparam logic [15:0] SOFTWARE_RESET_CONTROL_CONTROL_OFS = 16'h030c;

    // ************************************************************
    // Field positions of the hardware mode control word
    // ************************************************************
    localparam int TRANSCEIVER_RESET_BIT = 31;
    localparam int OC_SENSE_SELECT_BIT   = 15;
    localparam int BUS_WIDTH_BIT         = 8;
    localparam int DMA_ACK_POL_BIT       = 6;
    localparam int DMA_REQ_POL_BIT       = 5;
    localparam int IRQ_POLARITY_BIT      = 2;
    localparam int IRQ_EDGE_SELECT_BIT   = 1;
    localparam int IRQ_MASTER_EN_BIT     = 0;

    // Field positions of the software reset control word
    localparam int CTRL_REG_RESET_BIT = 1;
    localparam int ALL_REG_RESET_BIT  = 0;

    // ************************************************************
    // Values after reset, and the read value of unmapped offsets
    // ************************************************************
    localparam logic [31:0] HW_MODE_RESET   = 32'h0000_0100;
    localparam logic [31:0] SCRATCH_RESET   = 32'h0000_0000;
    localparam logic [1:0]  SOFTWARE_RESET_CONTROL_RESET  = 2'h0;
    localparam logic [31:0] UNMAPPED_RDATA  = 32'h0000_0000;

    // ************************************************************
    // Timing: width of the edge-mode interrupt pulse
    // ************************************************************
    localparam int SYS_CLK_PERIOD_NS = 10;
    localparam int IRQ_PULSE_NS      = 40;
    localparam int IRQ_PULSE_CYCLES  =
        (IRQ_PULSE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    // Interrupt shaper states
    typedef enum logic [0:0] {
        HCCFG_IRQ_IDLE  = 1'b0,
        HCCFG_IRQ_PULSE = 1'b1
    } hccfg_irq_state_e;

endpackage

// file: design/hccfg_regs.sv
// Configuration register group of the embedded host controller
`timescale 1ns/1ps

module hccfg_regs #(
    parameter logic [15:0] HW_VERSION = 16'h00a5, // Arbitrary value
    parameter logic [15:0] CHIP_IDENT = 16'h5a3c  // Arbitrary value
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // Processor register port
    input  wire logic        cpu_cs_i,
    input  wire logic        cpu_wr_i,
    input  wire logic        cpu_rd_i,
    input  wire logic [15:0] cpu_addr_i,
    input  wire logic [31:0] cpu_wdata_i,
    output logic      [31:0] cpu_rdata_o,
    output logic             cpu_rvalid_o,
    // Pins and internal event sources
    input  wire logic [2:0]  overcurrent_pins_n_i,
    input  wire logic [2:0]  overcurrent_analog_i,
    input  wire logic        dma_acknowledge_in_i,
    input  wire logic        dma_request_i,
    input  wire logic        irq_event_i,
    // Mode outputs
    output logic             transceiver_reset_o,
    output logic [2:0]       overcurrent_flags_o,
    output logic             bus_width_32_o,
    output logic             dma_ack_active_o,
    output logic             dma_request_out_o,
    output logic             irq_o,
    output logic             controller_register_reset_o,
    output logic             all_register_reset_o
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [3:0] pins_sync;

    hccfg_sync3 #(
        .WIDTH (4)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .async_i   ({dma_acknowledge_in_i, overcurrent_pins_n_i}),
        .sync_o    (pins_sync)
    );

    // ************************************************************
    // Register file
    // ************************************************************
    logic [31:0] hw_mode_r;
    logic [31:0] hw_mode_nxt;
    logic [31:0] scratch_r;
    logic [31:0] scratch_nxt;
    logic [1:0]  software_reset_control_r;
    logic [1:0]  software_reset_control_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        rvalid_r;
    logic        rvalid_nxt;
    logic        wr_en;
    logic        rd_en;

    function automatic logic hit(input logic [15:0] addr,
                                 input logic [15:0] ofs);
        hit = (addr == ofs);
    endfunction

    assign wr_en = cpu_cs_i && cpu_wr_i;
    assign rd_en = cpu_cs_i && cpu_rd_i && !cpu_wr_i;

    // Register writes; the full reset overrides writes to the mode and scratch words in the cycle
    always_comb begin
        hw_mode_nxt  = hw_mode_r;
        scratch_nxt  = scratch_r;
        software_reset_control_nxt = software_reset_control_r;
        // reserved bits stored
        // Reserved bits are kept as written since software owns them
        if (wr_en && hit(cpu_addr_i, hccfg_pkg::HARDWARE_MODE_CONTROL_OFS)) begin
            hw_mode_nxt = cpu_wdata_i;
        end
        if (wr_en && hit(cpu_addr_i, hccfg_pkg::SCRATCH_WORD_OFS)) begin
            scratch_nxt = cpu_wdata_i;
        end
        if (wr_en && hit(cpu_addr_i, hccfg_pkg::SOFTWARE_RESET_CONTROL_CONTROL_OFS)) begin
            software_reset_control_nxt = cpu_wdata_i[1:0];
        end
        if (software_reset_control_r[hccfg_pkg::ALL_REG_RESET_BIT]) begin
            hw_mode_nxt = hccfg_pkg::HW_MODE_RESET;
            scratch_nxt = hccfg_pkg::SCRATCH_RESET;
        end
    end

    // Read data registered one cycle after the strobe
    always_comb begin
        rvalid_nxt = rd_en;
        rdata_nxt  = rdata_r;
        if (rd_en) begin
            case (cpu_addr_i)
                hccfg_pkg::HARDWARE_MODE_CONTROL_OFS: rdata_nxt = hw_mode_r;
                hccfg_pkg::IDENTIFICATION_OFS:
                    rdata_nxt = {HW_VERSION, CHIP_IDENT};
                hccfg_pkg::SCRATCH_WORD_OFS:    rdata_nxt = scratch_r;
                hccfg_pkg::SOFTWARE_RESET_CONTROL_CONTROL_OFS:
                    rdata_nxt = {30'h0000_0000, software_reset_control_r};
                default:                         rdata_nxt =
                    hccfg_pkg::UNMAPPED_RDATA;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            hw_mode_r  <= hccfg_pkg::HW_MODE_RESET;
            scratch_r  <= hccfg_pkg::SCRATCH_RESET;
            software_reset_control_r <= hccfg_pkg::SOFTWARE_RESET_CONTROL_RESET;
            rdata_r    <= '0;
            rvalid_r   <= 1'b0;
        end else if (ce_i) begin
            hw_mode_r  <= hw_mode_nxt;
            scratch_r  <= scratch_nxt;
            software_reset_control_r <= software_reset_control_nxt;
            rdata_r    <= rdata_nxt;
            rvalid_r   <= rvalid_nxt;
        end
    end

    // ************************************************************
    // Interrupt shaper
    // ************************************************************
    localparam int PW = 8;
    localparam logic [PW-1:0] PULSE_LEN = PW'(hccfg_pkg::IRQ_PULSE_CYCLES);

    // The pulse counter must be able to hold the pulse length
    if (hccfg_pkg::IRQ_PULSE_CYCLES < 1 ||
        hccfg_pkg::IRQ_PULSE_CYCLES > (2 ** PW) - 1) begin : g_bad_pulse
        $error("interrupt pulse length does not fit its counter");
    end

    hccfg_pkg::hccfg_irq_state_e irq_state_r;
    hccfg_pkg::hccfg_irq_state_e irq_state_nxt;
    logic [PW-1:0] pulse_cnt_r;
    logic [PW-1:0] pulse_cnt_nxt;
    logic          event_d_r;
    logic          irq_active;
    logic          master_en;
    logic          edge_mode;

    assign master_en = hw_mode_r[hccfg_pkg::IRQ_MASTER_EN_BIT];
    assign edge_mode = hw_mode_r[hccfg_pkg::IRQ_EDGE_SELECT_BIT];

    // pulse or level
    // A new rising event during a pulse is merged into it
    always_comb begin
        irq_state_nxt = irq_state_r;
        pulse_cnt_nxt = pulse_cnt_r;
        case (irq_state_r)
            hccfg_pkg::HCCFG_IRQ_IDLE: begin
                if (irq_event_i && !event_d_r && edge_mode && master_en) begin
                    irq_state_nxt = hccfg_pkg::HCCFG_IRQ_PULSE;
                    pulse_cnt_nxt = PULSE_LEN - PW'(1);
                end
            end
            hccfg_pkg::HCCFG_IRQ_PULSE: begin
                if (pulse_cnt_r == '0 || !master_en) begin
                    irq_state_nxt = hccfg_pkg::HCCFG_IRQ_IDLE;
                end else begin
                    pulse_cnt_nxt = pulse_cnt_r - PW'(1);
                end
            end
            default: irq_state_nxt = hccfg_pkg::HCCFG_IRQ_IDLE;
        endcase
        if (!master_en) begin
            irq_active = 1'b0;
        end else if (edge_mode) begin
            irq_active = (irq_state_nxt == hccfg_pkg::HCCFG_IRQ_PULSE);
        end else begin
            irq_active = irq_event_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            irq_state_r <= hccfg_pkg::HCCFG_IRQ_IDLE;
            pulse_cnt_r <= '0;
            event_d_r   <= 1'b0;
        end else if (ce_i) begin
            irq_state_r <= irq_state_nxt;
            pulse_cnt_r <= pulse_cnt_nxt;
            event_d_r   <= irq_event_i;
        end
    end

    // ************************************************************
    // Output stage, every output from a flip-flop
    // ************************************************************
    logic [31:0] hw_nxt_out;
    logic        xcvr_rst_r;
    logic [2:0]  oc_flags_r;
    logic        bus32_r;
    logic        dma_acknowledge_in_r;
    logic        dma_request_out_r;
    logic        irq_pin_r;
    logic        ctrl_rst_r;
    logic        all_rst_r;
    logic        xcvr_rst_nxt;
    logic [2:0]  oc_flags_nxt;
    logic        dma_acknowledge_in_nxt;
    logic        dma_request_out_nxt;
    logic        irq_pin_nxt;

    assign hw_nxt_out = hw_mode_r;

    always_comb begin
        xcvr_rst_nxt = hw_nxt_out[hccfg_pkg::TRANSCEIVER_RESET_BIT];
        oc_flags_nxt = hw_nxt_out[hccfg_pkg::OC_SENSE_SELECT_BIT]
                     ? overcurrent_analog_i : ~pins_sync[2:0];
        dma_acknowledge_in_nxt = hw_nxt_out[hccfg_pkg::DMA_ACK_POL_BIT]
                 ? pins_sync[3] : ~pins_sync[3];
        dma_request_out_nxt = hw_nxt_out[hccfg_pkg::DMA_REQ_POL_BIT]
                 ? dma_request_i : ~dma_request_i;
        irq_pin_nxt = hw_nxt_out[hccfg_pkg::IRQ_POLARITY_BIT]
                    ? irq_active : ~irq_active;
    end

    // Analog flags arrive from on-chip comparators on this clock
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            xcvr_rst_r <= 1'b0;
            oc_flags_r <= '0;
            bus32_r    <= 1'b1;
            dma_acknowledge_in_r     <= 1'b0;
            dma_request_out_r     <= 1'b1;
            irq_pin_r  <= 1'b1;
            ctrl_rst_r <= 1'b0;
            all_rst_r  <= 1'b0;
        end else if (ce_i) begin
            xcvr_rst_r <= xcvr_rst_nxt;
            oc_flags_r <= oc_flags_nxt;
            bus32_r    <= hw_mode_r[hccfg_pkg::BUS_WIDTH_BIT];
            dma_acknowledge_in_r     <= dma_acknowledge_in_nxt;
            dma_request_out_r     <= dma_request_out_nxt;
            irq_pin_r  <= irq_pin_nxt;
            ctrl_rst_r <= software_reset_control_r[hccfg_pkg::CTRL_REG_RESET_BIT]
                        | software_reset_control_r[hccfg_pkg::ALL_REG_RESET_BIT];
            all_rst_r  <= software_reset_control_r[hccfg_pkg::ALL_REG_RESET_BIT];
        end
    end

    assign cpu_rdata_o                 = rdata_r;
    assign cpu_rvalid_o                = rvalid_r;
    assign transceiver_reset_o         = xcvr_rst_r;
    assign overcurrent_flags_o         = oc_flags_r;
    assign bus_width_32_o              = bus32_r;
    assign dma_ack_active_o            = dma_acknowledge_in_r;
    assign dma_request_out_o           = dma_request_out_r;
    assign irq_o                       = irq_pin_r;
    assign controller_register_reset_o = ctrl_rst_r;
    assign all_register_reset_o        = all_rst_r;

endmodule

// file: design/hccfg_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

module hccfg_sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    // Refuse an empty bus at elaboration
    if (WIDTH < 1) begin : g_bad_width
        $error("synchroniser width must be at least one");
    end

    // Accept a change only once the second and third stage agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            sync_nxt[i] = (stage2_r[i] == stage3_r[i]) ? stage3_r[i]
                                                       : sync_r[i];
        end
    end

    // The first stage feeds the second stage and nothing else
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            meta_r   <= '0;
            stage2_r <= '0;
            stage3_r <= '0;
            sync_r   <= '0;
        end else if (ce_i) begin
            meta_r   <= async_i;
            stage2_r <= meta_r;
            stage3_r <= stage2_r;
            sync_r   <= sync_nxt;
        end
    end

    assign sync_o = sync_r;

endmodule

// file: tb/hccfg_host_model.sv
// Host processor model driving the register port
`timescale 1ns/1ps
module hccfg_host_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] rdata_i,
    output logic             cs_o,
    output logic             wr_o,
    output logic             rd_o,
    output logic [15:0]      addr_o,
    output logic [31:0]      wdata_o
);
    // ************************************************************
    // Bus cycles; each is taken at the edge after it is set up
    // ************************************************************
    // Port idles before the first request
    initial begin
        {cs_o, wr_o, rd_o, addr_o, wdata_o} = '0;
    end
    // Write held up to its taking edge; reserved bits masked off
    task automatic put(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] m;
        m = (a == 16'h0300) ? 32'h8000_8167 :
            (a == 16'h030c) ? 32'h0000_0003 : 32'hffff_ffff;
        {cs_o, wr_o, rd_o, addr_o, wdata_o} <= {3'h6, a, d & m};
        @(posedge clk_i);
    endtask
    // Read held until its answer edge, data taken there
    task automatic get(input logic [15:0] a, output logic [31:0] d);
        {cs_o, wr_o, rd_o, addr_o} <= {3'h5, a};
        @(posedge clk_i);
        @(posedge clk_i);
        d = rdata_i;
    endtask
    // Release the port for one cycle
    task automatic idle;
        {cs_o, wr_o, rd_o} <= 3'h0;
        @(posedge clk_i);
    endtask
endmodule

// file: tb/hccfg_regs_sva.sv
// Port checker of the configuration register group
`timescale 1ns/1ps
module hccfg_regs_sva #(
    parameter logic [15:0] HW_VERSION = 16'h00a5, // Arbitrary value
    parameter logic [15:0] CHIP_IDENT = 16'h5a3c  // Arbitrary value
) (
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic        ce_i,
    input wire logic        cpu_cs_i,
    input wire logic        cpu_wr_i,
    input wire logic        cpu_rd_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic [31:0] cpu_wdata_i,
    input wire logic [31:0] cpu_rdata_o,
    input wire logic        cpu_rvalid_o,
    input wire logic        dma_request_i,
    input wire logic        irq_event_i,
    input wire logic        transceiver_reset_o,
    input wire logic        dma_request_out_o,
    input wire logic        irq_o,
    input wire logic        controller_register_reset_o,
    input wire logic        all_register_reset_o
);
    // ************************************************************
    // Shadow of the mode word
    // ************************************************************
    logic [31:0] mode_r;
    logic [31:0] mode_nxt;
    // Soft reset is not shadowed: the bench restores defaults before it
    always_comb begin
        mode_nxt = mode_r;
        if (ce_i && cpu_cs_i && cpu_wr_i && cpu_addr_i == 16'h0300) begin
            mode_nxt = cpu_wdata_i;
        end
    end
    // Shadow updates on the same edge as the stored word
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mode_r <= hccfg_pkg::HW_MODE_RESET;
        end else begin
            mode_r <= mode_nxt;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_wr(a);
        ce_i && cpu_cs_i && cpu_wr_i && cpu_addr_i == a;
    endsequence
    sequence s_rd(a);
        ce_i && cpu_cs_i && cpu_rd_i && !cpu_wr_i && cpu_addr_i == a;
    endsequence
    sequence s_rise;
        mode_r[0] && mode_r[1] && irq_o != mode_r[2] && $rose(irq_event_i);
    endsequence
    AST_XCVR_RST: assert property (
        s_wr(16'h0300) ##0 !all_register_reset_o |-> ##2
        transceiver_reset_o == $past(cpu_wdata_i[31], 2))
        else $error("transceiver reset does not follow bit 31");
    AST_RD_ANSWER: assert property (
        ce_i && cpu_cs_i && cpu_rd_i && !cpu_wr_i |=> cpu_rvalid_o)
        else $error("read got no valid strobe");
    AST_IDENT: assert property (
        s_rd(16'h0304) |=> cpu_rdata_o == {HW_VERSION, CHIP_IDENT})
        else $error("identification word wrong");
    AST_SCRATCH: assert property (
        s_wr(16'h0308) ##0 !all_register_reset_o ##1 s_rd(16'h0308)
        |=> cpu_rdata_o == $past(cpu_wdata_i, 2))
        else $error("scratch read differs from last write");
    AST_IRQ_OFF: assert property (
        !mode_r[0] |=> irq_o == !$past(mode_r[2]))
        else $error("interrupt active while disabled");
    AST_IRQ_LEVEL: assert property (
        mode_r[0] && !mode_r[1] |=>
        irq_o == ($past(irq_event_i) ~^ $past(mode_r[2])))
        else $error("level interrupt does not follow event");
    AST_IRQ_PULSE: assert property (
        s_rise |=> (irq_o == mode_r[2])[*4] ##1 irq_o != mode_r[2])
        else $error("interrupt pulse width wrong");
    AST_DMA_REQ: assert property (
        ce_i |=> dma_request_out_o ==
        ($past(dma_request_i) ~^ $past(mode_r[5])))
        else $error("request pin polarity wrong");
    AST_SW_ALL: assert property (
        s_wr(16'h030c) ##0 cpu_wdata_i[0] |-> ##2
        all_register_reset_o && controller_register_reset_o)
        else $error("full soft reset not raised");
    AST_SW_HC: assert property (
        s_wr(16'h030c) ##0 cpu_wdata_i[1:0] == 2'h2 |-> ##2
        controller_register_reset_o && !all_register_reset_o)
        else $error("controller soft reset wrong");
endmodule

// file: tb/hccfg_regs_tb.sv
// Self-checking bench of the configuration register group
`timescale 1ns/1ps
module hccfg_regs_tb;
    localparam logic [15:0] VER = 16'h00a5; // Arbitrary value
    localparam logic [15:0] CID = 16'h5a3c; // Arbitrary value
    logic        sys_clk_i, rst_n_i, cs, wr, rd, ack, req, ev, ce;
    logic        xrst, bw32, ackact, reqo, irq, crst, arst, rv;
    logic [2:0]  oc_n, oc_an, ocf;
    logic [15:0] addr;
    logic [31:0] wdata, rdata;
    int          n_fail, checks, cyc, k;
    // ************************************************************
    // Clock, reset, instances
    // ************************************************************
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    hccfg_regs #(.HW_VERSION(VER), .CHIP_IDENT(CID)) uut (.sys_clk_i,
        .rst_n_i, .ce_i(ce), .cpu_cs_i(cs), .cpu_wr_i(wr), .cpu_rd_i(rd),
        .cpu_addr_i(addr), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata),
        .cpu_rvalid_o(rv), .overcurrent_pins_n_i(oc_n),
        .overcurrent_analog_i(oc_an), .dma_acknowledge_in_i(ack),
        .dma_request_i(req), .irq_event_i(ev), .transceiver_reset_o(xrst),
        .overcurrent_flags_o(ocf), .bus_width_32_o(bw32),
        .dma_ack_active_o(ackact), .dma_request_out_o(reqo), .irq_o(irq),
        .controller_register_reset_o(crst), .all_register_reset_o(arst));
    hccfg_host_model host (.clk_i(sys_clk_i), .rdata_i(rdata), .cs_o(cs),
        .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
    // ************************************************************
    // Compare tasks and report
    // ************************************************************
    task automatic chk_word(string n, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("wrong value %s exp %h got %h", n, e, g);
            n_fail++;
        end
    endtask
    task automatic chk_pin(string n, logic e, logic g);
        checks++;
        if (g !== e) begin
            $display("wrong value %s exp %b got %b", n, e, g);
            n_fail++;
        end
    endtask
    task automatic rdc(logic [15:0] a, logic [31:0] e);
        logic [31:0] v;
        host.get(a, v);
        chk_word($sformatf("reg %h", a), e, v);
        host.idle();
    endtask
    task automatic wait_n(int n);
        repeat (n) host.idle();
    endtask
    task automatic final_report;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Hang guard: the whole run needs about 100 cycles
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            final_report();
        end
    end
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs;
        rdc(16'h0300, 32'h0000_0100);
        chk_pin("bus width", 1'b1, bw32);
        rdc(16'h0308, 32'h0);
        host.put(16'h0304, 32'hffff_ffff);
        rdc(16'h0304, {VER, CID});
        rdc(16'h0310, 32'h0);
        host.put(16'h0308, 32'ha5a5_0f0f);
        rdc(16'h0308, 32'ha5a5_0f0f);
    endtask
    // A write taken while the clock enable is low must not land
    task automatic t_freeze;
        ce <= 1'b0;
        host.put(16'h0308, 32'h0bad_f00d);
        host.idle();
        ce <= 1'b1;
        rdc(16'h0308, 32'ha5a5_0f0f);
    endtask
    task automatic t_mode;
        host.put(16'h0300, 32'h8000_0000);
        wait_n(2);
        chk_pin("xcvr reset", 1'b1, xrst);
        chk_pin("bus width", 1'b0, bw32);
        host.put(16'h0300, 32'h0000_0100);
        wait_n(2);
        chk_pin("xcvr reset", 1'b0, xrst);
    endtask
    task automatic t_pins;
        {oc_n, ack, req} <= 5'h17;
        host.put(16'h0300, 32'h0000_0160);
        wait_n(8);
        chk_word("oc flags", 32'h2, {29'h0, ocf});
        chk_pin("ack", 1'b1, ackact);
        chk_pin("req pin", 1'b1, reqo);
        {oc_an, ack} <= 4'hc;
        host.put(16'h0300, 32'h0000_8100);
        wait_n(8);
        chk_word("oc flags", 32'h6, {29'h0, ocf});
        chk_pin("ack", 1'b1, ackact);
        chk_pin("req pin", 1'b0, reqo);
        ack <= 1'b1;
        wait_n(8);
        chk_pin("ack", 1'b0, ackact);
    endtask
    task automatic t_irq;
        host.put(16'h0300, 32'h0000_0105);
        ev <= 1'b1;
        wait_n(2);
        chk_pin("irq", 1'b1, irq);
        host.put(16'h0300, 32'h0000_0101);
        wait_n(2);
        chk_pin("irq", 1'b0, irq);
        host.put(16'h0300, 32'h0000_0104);
        wait_n(2);
        chk_pin("irq", 1'b0, irq);
        ev <= 1'b0;
        host.put(16'h0300, 32'h0000_0107);
        wait_n(2);
        ev <= 1'b1;
        k = 0;
        for (int i = 0; i < 12; i++) begin
            host.idle();
            ev <= (i != 0);
            k += (irq === 1'b1);
        end
        chk_word("pulse cycles", 32'd4, k);
        ev <= 1'b0;
    endtask
    task automatic t_swreset;
        host.put(16'h0300, 32'h0000_0100);
        host.put(16'h0308, 32'h1234_5678);
        host.put(16'h030c, 32'h2);
        wait_n(2);
        chk_pin("hc reset", 1'b1, crst);
        chk_pin("all reset", 1'b0, arst);
        rdc(16'h0308, 32'h1234_5678);
        host.put(16'h030c, 32'h1);
        wait_n(2);
        chk_pin("all reset", 1'b1, arst);
        chk_pin("hc reset", 1'b1, crst);
        rdc(16'h0308, 32'h0);
        host.put(16'h030c, 32'h0);
        wait_n(2);
        chk_pin("all reset", 1'b0, arst);
    endtask
    // Main sequence
    initial begin
        {rst_n_i, oc_n, oc_an, ack, req, ev} = 10'h0;
        ce = 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        t_regs();
        t_freeze();
        t_mode();
        t_pins();
        t_irq();
        t_swreset();
        final_report();
    end
endmodule
bind hccfg_regs hccfg_regs_sva #(.HW_VERSION(HW_VERSION),
    .CHIP_IDENT(CHIP_IDENT)) u_sva (.sys_clk_i, .rst_n_i, .ce_i, .cpu_cs_i,
    .cpu_wr_i, .cpu_rd_i, .cpu_addr_i, .cpu_wdata_i, .cpu_rdata_o,
    .cpu_rvalid_o, .dma_request_i, .irq_event_i, .transceiver_reset_o,
    .dma_request_out_o, .irq_o, .controller_register_reset_o,
    .all_register_reset_o);
